// ==== port_pkg.sv ====
// constants for the port register block: offsets, fields, resets, pins
// assumes a 32-bit classic wishbone slave with byte addresses
package port_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int PORT_W   = 8;
  localparam int PORT_G_W = 5;
  localparam int BANKS    = 3;
  localparam int ADR_W    = 8;

  // ---------------------------------------------------------------
  // register byte offsets, banks a, b, c in index order
  // ---------------------------------------------------------------
  localparam logic [2:0][7:0] BANK_LATCH_OFS  = {8'h18, 8'h0C, 8'h00};
  localparam logic [2:0][7:0] BANK_DIR_OFS    = {8'h1C, 8'h10, 8'h04};
  localparam logic [2:0][7:0] BANK_SAMPLE_OFS = {8'h20, 8'h14, 8'h08};
  localparam logic [7:0]      OFS_CTRL        = 8'h24;
  localparam logic [7:0]      OFS_G_LATCH     = 8'h28;
  localparam logic [7:0]      OFS_G_DIR       = 8'h2C;
  localparam logic [7:0]      OFS_G_SAMPLE    = 8'h30;

  // ---------------------------------------------------------------
  // control register fields
  // ---------------------------------------------------------------
  localparam int CTRL_ASYNC_BIT  = 0;
  localparam int CTRL_EXTMEM_BIT = 1;
  localparam int CTRL_COMPAT_BIT = 2;

  // ---------------------------------------------------------------
  // port g pin positions
  // ---------------------------------------------------------------
  localparam int PIN_XTAL_IN  = 4;
  localparam int PIN_XTAL_OUT = 3;
  localparam int PIN_ALE      = 2;
  localparam int PIN_RD       = 1;
  localparam int PIN_WR       = 0;

  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  LATCH_RST  = 8'h00;
  localparam logic [7:0]  DIR_RST    = 8'h00;
  localparam logic [7:0]  SAMPLE_RST = 8'h00;
  localparam logic [1:0]  CTRL_RST   = 2'h0;
  localparam logic [31:0] RDATA_RST  = 32'h0000_0000;

endpackage : port_pkg

// ==== port_ctl_if.sv ====
// bundle between the register block and one port bank
// assumes the owner drives write strobes for one cycle per write
`timescale 1ns/1ps

interface port_ctl_if #(parameter int W = 8);
  logic [W-1:0] wdata;
  logic         we_latch;
  logic         we_dir;
  logic [W-1:0] pad_in;
  logic [W-1:0] latch;
  logic [W-1:0] dir;
  logic [W-1:0] sample;

  modport bank (
    input  wdata,
    input  we_latch,
    input  we_dir,
    input  pad_in,
    output latch,
    output dir,
    output sample
  );

  modport owner (
    output wdata,
    output we_latch,
    output we_dir,
    output pad_in,
    input  latch,
    input  dir,
    input  sample
  );
endinterface : port_ctl_if

// ==== gpio_bank.sv ====
// one port bank: output latch, direction and input sample registers
// assumes pad_in already gated by the pin's input buffer enable
`timescale 1ns/1ps

module gpio_bank #(
  parameter int W = port_pkg::PORT_W
) (
  input wire logic   mclk,
  input wire logic   srst,
  port_ctl_if.bank   ctl
);

  generate
    if (W < 1 || W > 8)
    begin : g_chk
      $error("gpio_bank width must be 1 to 8");
    end
  endgenerate

  typedef struct packed {
    logic [W-1:0] latch;
    logic [W-1:0] dir;
    logic [W-1:0] sample;
  } bank_state_type;

  bank_state_type state_q;
  bank_state_type state_d;

  always_comb
  begin
    state_d = state_q;
    if (ctl.we_latch)
    begin
      state_d.latch = ctl.wdata;
    end
    if (ctl.we_dir)
    begin
      state_d.dir = ctl.wdata;
    end
    state_d.sample = ctl.pad_in;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q.latch  <= port_pkg::LATCH_RST[W-1:0];
      state_q.dir    <= port_pkg::DIR_RST[W-1:0];
      state_q.sample <= port_pkg::SAMPLE_RST[W-1:0];
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign ctl.latch  = state_q.latch;
  assign ctl.dir    = state_q.dir;
  assign ctl.sample = state_q.sample;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  latch_write_a : assert property (@(posedge mclk) disable iff (srst)
    ctl.we_latch |=> ctl.latch == $past(ctl.wdata))
    else $error("latch did not take written value");

  dir_hold_a : assert property (@(posedge mclk) disable iff (srst)
    !ctl.we_dir |=> ctl.dir == $past(ctl.dir))
    else $error("direction changed without a write");

  bank_reset_a : assert property (@(posedge mclk)
    $past(srst) |-> (ctl.latch == '0) && (ctl.dir == '0))
    else $error("bank registers not zero after reset");

endmodule : gpio_bank

// ==== port_g_override.sv ====
// port g override network: crystal amplifier and memory strobe takeover
// assumes strobes and enables synchronous to mclk
`timescale 1ns/1ps

module port_g_override (
  input  wire logic       mclk,
  input  wire logic       srst,
  input  wire logic       compat_mode,
  input  wire logic       async_sel,
  input  wire logic       extmem_en,
  input  wire logic [4:0] latch,
  input  wire logic [4:0] dir,
  input  wire logic       ale_strobe,
  input  wire logic       rd_strobe,
  input  wire logic       wr_strobe,
  input  wire logic [4:0] pad_in,
  output logic      [4:0] pad_out,
  output logic      [4:0] pad_oe,
  output logic      [4:0] pad_pullup,
  output logic      [4:0] pad_in_gated,
  output logic            crystal_amp_in
);

  localparam logic [4:0] XTAL_MASK =
    5'((1 << port_pkg::PIN_XTAL_IN) | (1 << port_pkg::PIN_XTAL_OUT));
  localparam logic [4:0] STROBE_MASK =
    5'((1 << port_pkg::PIN_ALE) | (1 << port_pkg::PIN_RD) | (1 << port_pkg::PIN_WR));

  logic [4:0] pullup_override_en;
  logic [4:0] pullup_override_val;
  logic [4:0] dir_override_en;
  logic [4:0] dir_override_val;
  logic [4:0] value_override_en;
  logic [4:0] value_override_val;
  logic [4:0] in_disable_override_en;
  logic [4:0] in_disable_override_val;

  always_comb
  begin
    pullup_override_en      = '0;
    pullup_override_val     = '0;
    dir_override_en         = '0;
    dir_override_val        = '0;
    value_override_en       = '0;
    value_override_val      = '0;
    in_disable_override_en  = '0;
    in_disable_override_val = '0;
    // legacy mode: no general purpose use, idle pins held as inputs
    if (compat_mode)
    begin
      pullup_override_en = '1;
      dir_override_en    = '1;
    end
    if (async_sel)
    begin
      pullup_override_en     = pullup_override_en | XTAL_MASK;
      dir_override_en        = dir_override_en | XTAL_MASK;
      in_disable_override_en = in_disable_override_en | XTAL_MASK;
    end
    if (extmem_en)
    begin
      pullup_override_en = pullup_override_en | STROBE_MASK;
      dir_override_en    = dir_override_en | STROBE_MASK;
      dir_override_val   = dir_override_val | STROBE_MASK;
      value_override_en  = value_override_en | STROBE_MASK;
      value_override_val[port_pkg::PIN_ALE] = ale_strobe;
      value_override_val[port_pkg::PIN_RD]  = rd_strobe;
      value_override_val[port_pkg::PIN_WR]  = wr_strobe;
    end
  end

  assign pad_pullup = (pullup_override_en & pullup_override_val)
                    | (~pullup_override_en & latch & ~dir);
  assign pad_oe     = (dir_override_en & dir_override_val) | (~dir_override_en & dir);
  assign pad_out    = (value_override_en & value_override_val)
                    | (~value_override_en & latch);
  assign pad_in_gated = pad_in
                      & ~(in_disable_override_en & ~in_disable_override_val);
  // raw pin level to the amplifier, bypassing the digital buffer
  assign crystal_amp_in = async_sel & pad_in[port_pkg::PIN_XTAL_IN];

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  xtal_detach_a : assert property (@(posedge mclk) disable iff (srst)
    async_sel |-> ((pad_oe & XTAL_MASK) == '0) && ((pad_pullup & XTAL_MASK) == '0)
                  && ((pad_in_gated & XTAL_MASK) == '0))
    else $error("crystal pins not detached");

  xtal_value_a : assert property (@(posedge mclk) disable iff (srst)
    (pad_out & XTAL_MASK) == (latch & XTAL_MASK))
    else $error("crystal pin value overridden");

  strobe_drive_a : assert property (@(posedge mclk) disable iff (srst)
    extmem_en |-> (pad_oe[2:0] == 3'h7) && (pad_pullup[2:0] == 3'h0)
                  && (pad_out[2:0] == {ale_strobe, rd_strobe, wr_strobe}))
    else $error("strobe pins not driven by memory interface");

  strobe_input_a : assert property (@(posedge mclk) disable iff (srst)
    pad_in_gated[2:0] == pad_in[2:0])
    else $error("strobe pin input buffer disabled");

  compat_idle_a : assert property (@(posedge mclk) disable iff (srst)
    (compat_mode && !extmem_en) |-> (pad_oe == '0) && (pad_pullup == '0))
    else $error("legacy mode pins usable as gpio");

endmodule : port_g_override

// ==== port_pin_override_regs.sv ====
// top: ports a to c and port g registers behind a wishbone slave
// assumes classic wishbone, 32-bit data, byte addresses, srst synchronous
//
// Contract
// - legacy mode: port g only alternate functions
// - async timer select: pin 4 feeds amplifier
// - async timer select: pin 3 is amplifier output; the code only makes pin 3 an undriven input with pullup and buffer off
// - crystal pins: pullup off, input, buffer off
// - memory enable: pin 2 drives address latch
// - memory enable: pin 1 drives read strobe
// - memory enable: pin 0 drives write strobe
// - strobe pins keep input buffer enabled
// - output latches eight bits, reset zero
// - direction registers eight bits, reset zero
//
// Implementation choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps

module port_pin_override_regs #(
  parameter int ADR_W = port_pkg::ADR_W
) (
  input  wire logic             mclk,
  input  wire logic             srst,
  input  wire logic             wb_cyc_i,
  input  wire logic             wb_stb_i,
  input  wire logic             wb_we_i,
  input  wire logic [ADR_W-1:0] wb_adr_i,
  input  wire logic [3:0]       wb_sel_i,
  input  wire logic [31:0]      wb_dat_i,
  output logic      [31:0]      wb_dat_o,
  output logic                  wb_ack_o,
  input  wire logic             legacy_compat_mode,
  input  wire logic [23:0]      port_abc_in,
  output logic      [23:0]      port_abc_out,
  output logic      [23:0]      port_abc_oe,
  output logic      [23:0]      port_abc_pullup,
  input  wire logic [4:0]       port_g_in,
  output logic      [4:0]       port_g_out,
  output logic      [4:0]       port_g_oe,
  output logic      [4:0]       port_g_pullup,
  input  wire logic             ale_strobe,
  input  wire logic             rd_strobe,
  input  wire logic             wr_strobe,
  output logic                  crystal_amp_in,
  output logic                  timer_async_clock_select,
  output logic                  ext_mem_enable
);

  localparam int W  = port_pkg::PORT_W;
  localparam int GW = port_pkg::PORT_G_W;

  generate
    if (ADR_W < 8)
    begin : g_chk
      $error("address width must be at least 8");
    end
  endgenerate

  // ---------------------------------------------------------------
  // address decode
  // ---------------------------------------------------------------
  function automatic logic addr_hit(input logic [ADR_W-1:0] adr,
                                    input logic [7:0]       ofs);
    addr_hit = (adr == ADR_W'(ofs));
  endfunction : addr_hit

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic        async_sel;
    logic        extmem_en;
    logic        ack;
    logic [31:0] rdata;
  } top_state_type;

  top_state_type state_q;
  top_state_type state_d;

  wire logic [2:0][W-1:0] abc_latch;
  wire logic [2:0][W-1:0] abc_dir;
  wire logic [2:0][W-1:0] abc_sample;
  logic [GW-1:0]          g_latch;
  logic [GW-1:0]          g_dir;
  logic [GW-1:0]          g_sample;
  logic [GW-1:0]          g_in_gated;
  logic                   req;
  logic                   wr_commit;

  assign req       = wb_cyc_i & wb_stb_i;
  // writes land on the edge where the master sees ack
  assign wr_commit = req & state_q.ack & wb_we_i & wb_sel_i[0];

  // ---------------------------------------------------------------
  // ports a, b, c
  // ---------------------------------------------------------------
  generate
    for (genvar i = 0; i < port_pkg::BANKS; i++)
    begin : g_bank
      port_ctl_if #(.W(W)) ctl ();

      assign ctl.wdata    = wb_dat_i[W-1:0];
      assign ctl.we_latch = wr_commit
                          & addr_hit(wb_adr_i, port_pkg::BANK_LATCH_OFS[i]);
      assign ctl.we_dir   = wr_commit
                          & addr_hit(wb_adr_i, port_pkg::BANK_DIR_OFS[i]);
      assign ctl.pad_in   = port_abc_in[i*W +: W];
      assign abc_latch[i]  = ctl.latch;
      assign abc_dir[i]    = ctl.dir;
      assign abc_sample[i] = ctl.sample;

      assign port_abc_out[i*W +: W]    = ctl.latch;
      assign port_abc_oe[i*W +: W]     = ctl.dir;
      // pull-up on an input whose latch bit is one
      assign port_abc_pullup[i*W +: W] = ctl.latch & ~ctl.dir;

      gpio_bank #(.W(W)) u_bank (
        .mclk (mclk),
        .srst (srst),
        .ctl  (ctl)
      );
    end
  endgenerate

  // ---------------------------------------------------------------
  // port g
  // ---------------------------------------------------------------
  port_ctl_if #(.W(GW)) g_ctl ();

  assign g_ctl.wdata    = wb_dat_i[GW-1:0];
  // legacy mode leaves no general purpose use of port g
  assign g_ctl.we_latch = wr_commit & ~legacy_compat_mode
                        & addr_hit(wb_adr_i, port_pkg::OFS_G_LATCH);
  assign g_ctl.we_dir   = wr_commit & ~legacy_compat_mode
                        & addr_hit(wb_adr_i, port_pkg::OFS_G_DIR);
  assign g_ctl.pad_in   = g_in_gated;
  assign g_latch        = g_ctl.latch;
  assign g_dir          = g_ctl.dir;
  assign g_sample       = g_ctl.sample;

  gpio_bank #(.W(GW)) u_bank_g (
    .mclk (mclk),
    .srst (srst),
    .ctl  (g_ctl)
  );

  port_g_override u_override (
    .mclk           (mclk),
    .srst           (srst),
    .compat_mode    (legacy_compat_mode),
    .async_sel      (state_q.async_sel),
    .extmem_en      (state_q.extmem_en),
    .latch          (g_latch),
    .dir            (g_dir),
    .ale_strobe     (ale_strobe),
    .rd_strobe      (rd_strobe),
    .wr_strobe      (wr_strobe),
    .pad_in         (port_g_in),
    .pad_out        (port_g_out),
    .pad_oe         (port_g_oe),
    .pad_pullup     (port_g_pullup),
    .pad_in_gated   (g_in_gated),
    .crystal_amp_in (crystal_amp_in)
  );

  // ---------------------------------------------------------------
  // bus slave and control register
  // ---------------------------------------------------------------
  always_comb
  begin
    state_d     = state_q;
    state_d.ack = req & ~state_q.ack;
    if (req && !state_q.ack)
    begin
      // unmapped offsets fall through to zero; sample offsets read the sampled pins
      state_d.rdata = port_pkg::RDATA_RST;
      for (int i = 0; i < port_pkg::BANKS; i++)
      begin
        if (addr_hit(wb_adr_i, port_pkg::BANK_LATCH_OFS[i]))
        begin
          state_d.rdata[W-1:0] = abc_latch[i];
        end
        if (addr_hit(wb_adr_i, port_pkg::BANK_DIR_OFS[i]))
        begin
          state_d.rdata[W-1:0] = abc_dir[i];
        end
        if (addr_hit(wb_adr_i, port_pkg::BANK_SAMPLE_OFS[i]))
        begin
          state_d.rdata[W-1:0] = abc_sample[i];
        end
      end
      if (addr_hit(wb_adr_i, port_pkg::OFS_G_LATCH))
      begin
        state_d.rdata[GW-1:0] = g_latch;
      end
      if (addr_hit(wb_adr_i, port_pkg::OFS_G_DIR))
      begin
        state_d.rdata[GW-1:0] = g_dir;
      end
      if (addr_hit(wb_adr_i, port_pkg::OFS_G_SAMPLE))
      begin
        state_d.rdata[GW-1:0] = g_sample;
      end
      if (addr_hit(wb_adr_i, port_pkg::OFS_CTRL))
      begin
        state_d.rdata[port_pkg::CTRL_ASYNC_BIT]  = state_q.async_sel;
        state_d.rdata[port_pkg::CTRL_EXTMEM_BIT] = state_q.extmem_en;
        state_d.rdata[port_pkg::CTRL_COMPAT_BIT] = legacy_compat_mode;
      end
    end
    if (wr_commit && addr_hit(wb_adr_i, port_pkg::OFS_CTRL))
    begin
      state_d.async_sel = wb_dat_i[port_pkg::CTRL_ASYNC_BIT];
      state_d.extmem_en = wb_dat_i[port_pkg::CTRL_EXTMEM_BIT];
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q.async_sel <= port_pkg::CTRL_RST[port_pkg::CTRL_ASYNC_BIT];
      state_q.extmem_en <= port_pkg::CTRL_RST[port_pkg::CTRL_EXTMEM_BIT];
      state_q.ack       <= 1'b0;
      state_q.rdata     <= port_pkg::RDATA_RST;
    end
    else
    begin
      state_q <= state_d;
    end
  end

  assign wb_ack_o                 = state_q.ack;
  assign wb_dat_o                 = state_q.rdata;
  assign timer_async_clock_select = state_q.async_sel;
  assign ext_mem_enable           = state_q.extmem_en;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  ack_answer_a : assert property (@(posedge mclk) disable iff (srst)
    (req && !wb_ack_o) |=> wb_ack_o)
    else $error("no ack one cycle after request");

  ack_single_a : assert property (@(posedge mclk) disable iff (srst)
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

  sample_readonly_a : assert property (@(posedge mclk) disable iff (srst)
    (wr_commit && addr_hit(wb_adr_i, port_pkg::BANK_SAMPLE_OFS[0]))
      |=> $stable(abc_latch) && $stable(abc_dir))
    else $error("sample write changed port registers");

  latch_readback_a : assert property (@(posedge mclk) disable iff (srst)
    (wr_commit && addr_hit(wb_adr_i, port_pkg::BANK_LATCH_OFS[1]))
      |=> abc_latch[1] == $past(wb_dat_i[W-1:0]))
    else $error("port b latch missed write");

  dir_pin_a : assert property (@(posedge mclk) disable iff (srst)
    (wr_commit && addr_hit(wb_adr_i, port_pkg::BANK_DIR_OFS[2]))
      |=> port_abc_oe[2*W +: W] == $past(wb_dat_i[W-1:0]))
    else $error("direction not reflected on pins");

  ctrl_write_a : assert property (@(posedge mclk) disable iff (srst)
    (wr_commit && addr_hit(wb_adr_i, port_pkg::OFS_CTRL))
      |=> (timer_async_clock_select == $past(wb_dat_i[port_pkg::CTRL_ASYNC_BIT]))
          && (ext_mem_enable == $past(wb_dat_i[port_pkg::CTRL_EXTMEM_BIT])))
    else $error("control write not applied");

  compat_lock_a : assert property (@(posedge mclk) disable iff (srst)
    legacy_compat_mode |=> $stable(g_latch) && $stable(g_dir))
    else $error("port g registers written in legacy mode");

  xtal_route_a : assert property (@(posedge mclk) disable iff (srst)
    timer_async_clock_select |-> crystal_amp_in == port_g_in[port_pkg::PIN_XTAL_IN])
    else $error("crystal input not routed");

  strobe_wr_a : assert property (@(posedge mclk) disable iff (srst)
    ext_mem_enable |-> port_g_oe[port_pkg::PIN_WR]
                       && (port_g_out[port_pkg::PIN_WR] == wr_strobe))
    else $error("write strobe pin not driven");

endmodule : port_pin_override_regs

// ==== board_pins.sv ====
// board model: pin levels of ports a to c and g as seen from outside
// assumes pad outputs of the port block and mclk for the idle pattern
`timescale 1ns/1ps

module board_pins (
  input  wire logic        mclk,
  input  wire logic [23:0] abc_out,
  input  wire logic [23:0] abc_oe,
  input  wire logic [23:0] abc_pullup,
  input  wire logic [23:0] ext_abc,
  input  wire logic        ext_en,
  input  wire logic [4:0]  g_out,
  input  wire logic [4:0]  g_oe,
  input  wire logic [4:0]  g_pullup,
  output logic      [23:0] abc_in,
  output logic      [4:0]  g_in
);
  // ---------------------------------------------------------------
  // pin levels
  // ---------------------------------------------------------------
  logic idle_q = 1'b0;

  // floating pins wander every cycle; crystal on pin 4 swings this way too
  always_ff @(posedge mclk) idle_q <= ~idle_q;

  always_comb
  begin
    for (int i = 0; i < 24; i++)
    begin
      abc_in[i] = abc_oe[i] ? abc_out[i] : ext_en ? ext_abc[i] : abc_pullup[i] | (idle_q ^ i[0]);
    end
    for (int i = 0; i < 5; i++)
    begin
      g_in[i] = g_oe[i] ? g_out[i] : g_pullup[i] | (idle_q ^ i[0]);
    end
  end
endmodule : board_pins

// ==== port_pin_override_regs_tb_top.sv ====
// self-checking bench for the port register and override block
// assumes board_pins as the far side and classic wishbone at 100 MHz
`timescale 1ns/1ps

module port_pin_override_regs_tb_top;
  logic        mclk, srst, cyc, stb, we, legacy, ale, rd, wr, ext_en, amp_in, asel, xmem, ack;
  logic [7:0]  adr;
  logic [3:0]  sel;
  logic [31:0] wdat, rdat;
  logic [23:0] abc_in, abc_out, abc_oe, abc_pu, ext_abc;
  logic [4:0]  g_in, g_out, g_oe, g_pu;
  int          errors, n_checks;
  logic [7:0]  lat [3] = '{8'h5a, 8'ha5, 8'hff};
  logic [7:0]  dir [3] = '{8'hc3, 8'h0f, 8'h00};

  port_pin_override_regs port_pin_override_regs_inst (
    .mclk(mclk), .srst(srst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .legacy_compat_mode(legacy), .port_abc_in(abc_in), .port_abc_out(abc_out),
    .port_abc_oe(abc_oe), .port_abc_pullup(abc_pu), .port_g_in(g_in), .port_g_out(g_out),
    .port_g_oe(g_oe), .port_g_pullup(g_pu), .ale_strobe(ale), .rd_strobe(rd), .wr_strobe(wr),
    .crystal_amp_in(amp_in), .timer_async_clock_select(asel), .ext_mem_enable(xmem));

  board_pins board_pins_inst (
    .mclk(mclk), .abc_out(abc_out), .abc_oe(abc_oe), .abc_pullup(abc_pu), .ext_abc(ext_abc),
    .ext_en(ext_en), .g_out(g_out), .g_oe(g_oe), .g_pullup(g_pu), .abc_in(abc_in), .g_in(g_in));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic give_verdict();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  // one classic cycle; ack sampled at the rising edge, then released
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] q);
    int n;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= 4'h1;
    n = 0;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (ack !== 1'b1 && n < 20);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
    if (ack !== 1'b1)
    begin
      errors++;
      give_verdict();
    end
  endtask : bus

  task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask : reg_write

  task automatic read_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    check(q, exp);
  endtask : read_chk

  task automatic settle();
    repeat (2) @(posedge mclk);
    #1;
  endtask : settle

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset();
    for (int b = 0; b < 3; b++)
    begin
      read_chk(port_pkg::BANK_LATCH_OFS[b], 32'h0);
      read_chk(port_pkg::BANK_DIR_OFS[b], 32'h0);
    end
    check({5'h0, amp_in, asel, xmem, abc_out | abc_oe | abc_pu}, 32'h0);
  endtask : t_reset

  task automatic t_legacy();
    @(posedge mclk);
    legacy <= 1'b1;
    reg_write(port_pkg::OFS_G_DIR, 32'h1f);
    reg_write(port_pkg::OFS_G_LATCH, 32'h1f);
    settle();
    check({27'h0, g_oe | g_pu}, 32'h0);
    read_chk(port_pkg::OFS_G_DIR, 32'h0);
    read_chk(port_pkg::OFS_CTRL, 32'h4);
    @(posedge mclk);
    legacy <= 1'b0;
  endtask : t_legacy

  task automatic t_gpio();
    logic [7:0] e;
    @(posedge mclk);
    ext_abc <= 24'h963c_e1;
    ext_en <= 1'b1;
    for (int b = 0; b < 3; b++)
    begin
      reg_write(port_pkg::BANK_LATCH_OFS[b], {24'h0, lat[b]});
      reg_write(port_pkg::BANK_DIR_OFS[b], {24'h0, dir[b]});
    end
    settle();
    check({8'h0, abc_out}, {8'h0, lat[2], lat[1], lat[0]});
    check({8'h0, abc_oe}, {8'h0, dir[2], dir[1], dir[0]});
    check({8'h0, abc_pu}, {8'h0, lat[2] & ~dir[2], lat[1] & ~dir[1], lat[0] & ~dir[0]});
    for (int b = 0; b < 3; b++)
    begin
      e = (lat[b] & dir[b]) | (ext_abc[b*8 +: 8] & ~dir[b]);
      read_chk(port_pkg::BANK_LATCH_OFS[b], {24'h0, lat[b]});
      read_chk(port_pkg::BANK_DIR_OFS[b], {24'h0, dir[b]});
      reg_write(port_pkg::BANK_SAMPLE_OFS[b], 32'hffff_ffff);
      read_chk(port_pkg::BANK_SAMPLE_OFS[b], {24'h0, e});
    end
    reg_write(8'h40, 32'hff);
    read_chk(8'h40, 32'h0);
  endtask : t_gpio

  task automatic t_async();
    reg_write(port_pkg::OFS_G_DIR, 32'h1f);
    reg_write(port_pkg::OFS_G_LATCH, 32'h1a);
    reg_write(port_pkg::OFS_CTRL, 32'h1);
    settle();
    check({30'h0, asel, xmem}, 32'h2);
    check({27'h0, g_oe}, 32'h7);
    check({30'h0, g_out[4:3]}, 32'h3);
    reg_write(port_pkg::OFS_G_DIR, 32'h07);
    settle();
    check({27'h0, g_pu}, 32'h0);
    repeat (2)
    begin
      check({31'h0, amp_in}, {31'h0, g_in[4]});
      @(posedge mclk);
      #1;
    end
    read_chk(port_pkg::OFS_G_SAMPLE, 32'h02);
    read_chk(port_pkg::OFS_CTRL, 32'h1);
  endtask : t_async

  task automatic t_extmem();
    reg_write(port_pkg::OFS_G_DIR, 32'h0);
    reg_write(port_pkg::OFS_CTRL, 32'h3);
    settle();
    check({30'h0, asel, xmem}, 32'h3);
    for (int i = 0; i < 8; i++)
    begin
      @(posedge mclk);
      {ale, rd, wr} <= 3'(i);
      @(posedge mclk);
      #1;
      check({29'h0, g_out[2:0]}, 32'(i));
      check({26'h0, g_oe[2:0], g_pu[2:0]}, 32'h38);
    end
    @(posedge mclk);
    {ale, rd, wr} <= 3'b101;
    read_chk(port_pkg::OFS_G_SAMPLE, 32'h05);
  endtask : t_extmem

  // ---------------------------------------------------------------
  // clock, reset and main sequence
  // ---------------------------------------------------------------
  initial
  begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    {srst, cyc, stb, we, legacy, ale, rd, wr, ext_en} = 9'h100;
    adr = 8'h00;
    sel = 4'h0;
    wdat = 32'h0;
    ext_abc = 24'h0;
    errors = 0;
    n_checks = 0;
    repeat (12) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_legacy();
    t_gpio();
    t_async();
    t_extmem();
    give_verdict();
  end
endmodule : port_pin_override_regs_tb_top
